// File: bench/qrr_sensor_model.sv
/*
 Temperature sensor reader model: answers each start pulse with a done
 pulse and a code after a set number of idle cycles.
 Assumes the responder's clock and its synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module qrr_sensor_model
    import qrr_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    input  wire logic              temp_start_i,
    input  wire logic [7:0]        delay_i,
    input  wire logic [TEMP_W-1:0] code_i,
    output logic                   temp_done_o,
    output logic      [TEMP_W-1:0] temp_code_o
);
    logic [7:0] cnt_reg;
    logic       busy_reg;

    always_ff @(posedge clk_i)
    begin
        temp_done_o <= 1'h0;
        // Code lines toggle outside the done cycle and reset
        temp_code_o <= ~temp_code_o;
        if (!resetn_i)
        begin
            busy_reg    <= 1'h0;
            temp_code_o <= '0;
        end
        else if (temp_start_i)
        begin
            busy_reg <= 1'h1;
            cnt_reg  <= delay_i;
        end
        else if (busy_reg && cnt_reg == 8'h00)
        begin
            busy_reg    <= 1'h0;
            temp_done_o <= 1'h1;
            temp_code_o <= code_i;
        end
        else if (busy_reg)
            cnt_reg <= cnt_reg - 8'h01;
    end
endmodule : qrr_sensor_model

`default_nettype wire

// File: bench/query_request_responder_bench.sv
/*
 Bench of the query request responder: a table of requests with their
 expected answers, then slow sensor, mid-run reset and back-to-back cases.
 Assumes qrr_pkg, the responder and the sensor reader model are compiled.
*/
`timescale 1ns/1ps
`default_nettype none

module query_request_responder_bench
    import qrr_pkg::*;
;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [31:0] val;
        logic [15:0] st;
        logic [13:0] code;
        logic        err;
        logic [31:0] word;
    } qrr_row_t;

    logic        clk_i, resetn_i, req_valid_i, req_ready_o, resp_valid_o, resp_error_o;
    logic        temp_start_o, temp_done_i, cal_load_en_i, user_load_en_i, err;
    logic [7:0]  req_cmd_i, status_request_o, temperature_request_o, delay, load_data_i;
    logic [31:0] instruction_value_i, returned_word_o, word;
    logic [15:0] st, calibration_memory_read_request_o, user_memory_read_request_o;
    logic [13:0] temp_code_i, code, load_addr_i;
    logic [31:0] packed_word;
    int          failures, checked, i, base;
    int          resp_count = 0;
    qrr_row_t    rows [14];

    qrr_responder u_qrr_responder (
        .clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
        .instruction_value_i(instruction_value_i), .req_ready_o(req_ready_o),
        .resp_valid_o(resp_valid_o), .resp_error_o(resp_error_o), .returned_word_o(returned_word_o),
        .temp_compensated_crystal_osc_lock_i(st[15]), .voltage_tuned_crystal_osc_lock_i(st[14]),
        .first_local_oscillator_main_lock_i(st[13]), .second_local_oscillator_lock_i(st[12]),
        .third_local_oscillator_lock_i(st[11]), .first_local_oscillator_aux1_lock_i(st[10]),
        .first_local_oscillator_aux2_lock_i(st[9]), .ext_ref_detect_i(st[7]),
        .ref_out_enable_i(st[6]), .ref_lock_enable_i(st[5]), .second_if_filter_path_i(st[4]),
        .standby_enable_i(st[2]), .backplane_ten_mhz_reference_i(st[1]),
        .temp_start_o(temp_start_o), .temp_done_i(temp_done_i), .temp_code_i(temp_code_i),
        .cal_load_en_i(cal_load_en_i), .user_load_en_i(user_load_en_i),
        .load_addr_i(load_addr_i), .load_data_i(load_data_i),
        .status_request_o(status_request_o), .temperature_request_o(temperature_request_o),
        .calibration_memory_read_request_o(calibration_memory_read_request_o),
        .user_memory_read_request_o(user_memory_read_request_o)
    );

    qrr_sensor_model u_qrr_sensor_model (
        .clk_i(clk_i), .resetn_i(resetn_i), .temp_start_i(temp_start_o), .delay_i(delay),
        .code_i(code), .temp_done_o(temp_done_i), .temp_code_o(temp_code_i)
    );

    initial
    begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    always @(negedge clk_i)
        if (resp_valid_o === 1'h1)
            resp_count++;

    task automatic final_report();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic request(input logic [7:0] cmd, input logic [31:0] val);
        @(posedge clk_i);
        req_valid_i         <= 1'h1;
        req_cmd_i           <= cmd;
        instruction_value_i <= val;
        @(posedge clk_i);
        req_valid_i         <= 1'h0;
    endtask : request

    task automatic wait_resp(output logic e, output logic [31:0] w);
        int n;
        for (n = 0; n < 200; n++)
        begin
            @(negedge clk_i);
            if (resp_valid_o === 1'h1)
                break;
        end
        if (n == 200)
        begin
            failures++;
            final_report();
        end
        e = resp_error_o;
        w = returned_word_o;
    endtask : wait_resp

    task automatic load(input logic user, input logic [13:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cal_load_en_i  <= !user;
        user_load_en_i <= user;
        load_addr_i    <= a;
        load_data_i    <= d;
        @(posedge clk_i);
        cal_load_en_i  <= 1'h0;
        user_load_en_i <= 1'h0;
    endtask : load

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        failures = 0;
        checked = 0;
        resetn_i = 1'h0;
        req_valid_i = 1'h0;
        req_cmd_i = 8'h00;
        instruction_value_i = 32'h0;
        st = 16'h0000;
        code = 14'h0000;
        delay = 8'h00;
        cal_load_en_i = 1'h0;
        user_load_en_i = 1'h0;
        load_addr_i = 14'h0000;
        load_data_i = 8'h00;
        rows = '{
            '{8'h18, 32'h1, 16'hFFFF, 14'h0, 1'h0, 32'h0000_FEF6},
            '{8'h18, 32'h1, 16'hA4A4, 14'h0, 1'h0, 32'h0000_A4A4},
            '{8'h18, 32'h1, 16'h5A52, 14'h0, 1'h0, 32'h0000_5A52},
            '{8'h18, 32'h1, 16'h0000, 14'h0, 1'h0, 32'h0000_0000},
            '{8'h19, 32'h0, 16'h0000, 14'h2ABC, 1'h0, 32'h0000_2ABC},
            '{8'h19, 32'h0, 16'h0000, 14'h0320, 1'h0, 32'h0000_0320},
            '{8'h20, 32'h4005, 16'h0000, 14'h0, 1'h0, 32'h0000_005C},
            '{8'h20, 32'h0005, 16'h0000, 14'h0, 1'h0, 32'h0000_005C},
            '{8'h20, 32'h3FFF, 16'h0000, 14'h0, 1'h0, 32'h0000_00E1},
            '{8'h22, 32'h0005, 16'h0000, 14'h0, 1'h0, 32'h0000_003A},
            '{8'h22, 32'hC005, 16'h0000, 14'h0, 1'h0, 32'h0000_003A},
            '{8'h18, 32'h2, 16'h0000, 14'h0, 1'h1, 32'h0000_0000},
            '{8'h19, 32'h1, 16'h0000, 14'h0, 1'h1, 32'h0000_0000},
            '{8'h21, 32'h0, 16'h0000, 14'h0, 1'h1, 32'h0000_0000}
        };
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'h1;
        @(negedge clk_i);
        check({status_request_o, temperature_request_o, calibration_memory_read_request_o}, 32'h0);
        check({user_memory_read_request_o, 14'h0, req_ready_o, resp_valid_o}, 32'h0000_0002);
        check(returned_word_o, 32'h0);
        load(1'h0, 14'h0005, 8'h5C);
        load(1'h0, 14'h3FFF, 8'hE1);
        load(1'h1, 14'h0005, 8'h3A);
        for (i = 0; i < 14; i++)
        begin
            @(posedge clk_i);
            st   <= rows[i].st;
            code <= rows[i].code;
            repeat (6) @(posedge clk_i);
            request(rows[i].cmd, rows[i].val);
            wait_resp(err, word);
            check({31'h0, err}, {31'h0, rows[i].err});
            check(word, rows[i].word);
            if (rows[i].cmd == STATUS_REQUEST_OFS && !rows[i].err)
                check({31'h0, word[13] & word[10] & word[9]}, {31'h0, (rows[i].st & 16'h2600) == 16'h2600});
        end
        check({status_request_o, temperature_request_o, calibration_memory_read_request_o}, 32'h0201_3FFF);
        check({user_memory_read_request_o, 16'h0000}, 32'hC005_0000);

        // Four calibration bytes assembled low address first
        load(1'h0, 14'h0008, 8'h78);
        load(1'h0, 14'h0009, 8'h56);
        load(1'h0, 14'h000A, 8'h34);
        load(1'h0, 14'h000B, 8'h12);
        packed_word = 32'h0;
        for (i = 0; i < 4; i++)
        begin
            request(8'h20, 32'h8 + i);
            wait_resp(err, word);
            packed_word = packed_word | (word << (8 * i));
        end
        check(packed_word, 32'h1234_5678);

        // Slow sensor: start pulse lasts one cycle, port busy meanwhile
        delay <= 8'h14;
        code  <= 14'h1FFF;
        request(8'h19, 32'h0);
        @(negedge clk_i);
        check({30'h0, temp_start_o, req_ready_o}, 32'h2);
        @(negedge clk_i);
        check({30'h0, temp_start_o, req_ready_o}, 32'h0);
        wait_resp(err, word);
        check(word, 32'h0000_1FFF);
        check(word & TEMP_SIGN_MASK, 32'h0);
        check((word & 32'h0000_1FFF) >> 5, 32'h0000_00FF);

        // Reset in mid-run clears answer and request registers
        @(posedge clk_i);
        resetn_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'h1;
        @(negedge clk_i);
        check({status_request_o, temperature_request_o, calibration_memory_read_request_o}, 32'h0);
        check(returned_word_o, 32'h0);
        check({user_memory_read_request_o, 14'h0, req_ready_o, resp_valid_o}, 32'h0000_0002);

        // Two status requests taken on consecutive edges
        @(posedge clk_i);
        base = resp_count;
        req_valid_i         <= 1'h1;
        req_cmd_i           <= 8'h18;
        instruction_value_i <= 32'h1;
        repeat (2) @(posedge clk_i);
        req_valid_i <= 1'h0;
        repeat (3) @(negedge clk_i);
        check(resp_count - base, 32'h2);
        final_report();
    end
endmodule : query_request_responder_bench

`default_nettype wire

// File: design/qrr_byte_mem.sv
/*
 Byte memory of 16k locations, one write port, one read port with
 registered read data (one cycle latency).
 Assumes a single clock; contents are loaded through the write port.
*/
`timescale 1ns/1ps
`default_nettype none

module qrr_byte_mem
    import qrr_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              wr_en_i,
    input  wire logic [MEM_AW-1:0] wr_addr_i,
    input  wire logic [MEM_DW-1:0] wr_data_i,
    input  wire logic              rd_en_i,
    input  wire logic [MEM_AW-1:0] rd_addr_i,
    output logic      [MEM_DW-1:0] rd_data_o
);

    logic [MEM_DW-1:0] mem_array [0:(1<<MEM_AW)-1];
    logic [MEM_DW-1:0] rd_data_reg;

    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem_array[wr_addr_i] <= wr_data_i;
        end
        if (rd_en_i)
        begin
            rd_data_reg <= mem_array[rd_addr_i];
        end
    end

    assign rd_data_o = rd_data_reg;

endmodule : qrr_byte_mem

`default_nettype wire

// File: design/qrr_responder.sv
/*
 Query request responder: takes request register writes (command byte
 plus instruction value) and answers with a 32-bit returned word for
 status, temperature, calibration memory and user memory reads.
 Assumes the host holds a request until req_ready_o, a temperature
 sensor reader on the same clock, and lock pins from other clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module qrr_responder
    import qrr_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    // Request port
    input  wire logic              req_valid_i,
    input  wire logic [7:0]        req_cmd_i,
    input  wire logic [31:0]       instruction_value_i,
    output logic                   req_ready_o,
    output logic                   resp_valid_o,
    output logic                   resp_error_o,
    output logic      [31:0]       returned_word_o,
    // Lock and detect pins (asynchronous)
    input  wire logic              temp_compensated_crystal_osc_lock_i,
    input  wire logic              voltage_tuned_crystal_osc_lock_i,
    input  wire logic              first_local_oscillator_main_lock_i,
    input  wire logic              second_local_oscillator_lock_i,
    input  wire logic              third_local_oscillator_lock_i,
    input  wire logic              first_local_oscillator_aux1_lock_i,
    input  wire logic              first_local_oscillator_aux2_lock_i,
    input  wire logic              ext_ref_detect_i,
    // Configuration levels (same clock)
    input  wire logic              ref_out_enable_i,
    input  wire logic              ref_lock_enable_i,
    input  wire logic              second_if_filter_path_i,
    input  wire logic              standby_enable_i,
    input  wire logic              backplane_ten_mhz_reference_i,
    // Temperature sensor reader
    output logic                   temp_start_o,
    input  wire logic              temp_done_i,
    input  wire logic [TEMP_W-1:0] temp_code_i,
    // Memory load ports
    input  wire logic              cal_load_en_i,
    input  wire logic              user_load_en_i,
    input  wire logic [MEM_AW-1:0] load_addr_i,
    input  wire logic [MEM_DW-1:0] load_data_i,
    // Request register contents
    output logic      [7:0]        status_request_o,
    output logic      [7:0]        temperature_request_o,
    output logic      [15:0]       calibration_memory_read_request_o,
    output logic      [15:0]       user_memory_read_request_o
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_s1_reg;
    logic [PIN_COUNT-1:0] pin_s2_reg;
    logic [PIN_COUNT-1:0] pin_s3_reg;
    logic [PIN_COUNT-1:0] pin_reg;
    logic [PIN_COUNT-1:0] pin_agree;
    logic [PIN_COUNT-1:0] pin_next;

    assign pin_raw = {temp_compensated_crystal_osc_lock_i, voltage_tuned_crystal_osc_lock_i,
                      first_local_oscillator_main_lock_i, second_local_oscillator_lock_i,
                      third_local_oscillator_lock_i, first_local_oscillator_aux1_lock_i,
                      first_local_oscillator_aux2_lock_i, ext_ref_detect_i};
    assign pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
    assign pin_next  = (pin_agree & pin_s3_reg) | (~pin_agree & pin_reg);

    always_ff @(posedge clk_i)
    begin
        pin_s1_reg <= pin_raw;
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
        if (!resetn_i)
        begin
            pin_reg <= '0;
        end
        else
        begin
            pin_reg <= pin_next;
        end
    end

    // ------------------------------------------------------------
    // Status word assembly
    // ------------------------------------------------------------
    logic [15:0] status_word;

    always_comb
    begin
        status_word                   = 16'h0000;
        status_word[ST_TEMP_COMPENSATED_CRYSTAL_OSC_LOCK_BIT] = pin_reg[7];
        status_word[ST_VOLTAGE_TUNED_CRYSTAL_OSC_LOCK_BIT] = pin_reg[6];
        status_word[ST_LO1_MAIN_BIT]  = pin_reg[5];
        status_word[ST_LO2_LOCK_BIT]  = pin_reg[4];
        status_word[ST_LO3_LOCK_BIT]  = pin_reg[3];
        status_word[ST_LO1_AUX1_BIT]  = pin_reg[2];
        status_word[ST_LO1_AUX2_BIT]  = pin_reg[1];
        status_word[ST_EXT_REF_BIT]   = pin_reg[0];
        status_word[ST_REF_OUT_BIT]   = ref_out_enable_i;
        status_word[ST_REF_LOCK_BIT]  = ref_lock_enable_i;
        status_word[ST_IF_PATH_BIT]   = second_if_filter_path_i;
        status_word[ST_STANDBY_BIT]   = standby_enable_i;
        status_word[ST_BACKPLANE_BIT] = backplane_ten_mhz_reference_i;
    end

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    qrr_state_t  state_reg;
    qrr_state_t  state_next;
    logic        req_take;
    logic        is_status;
    logic        is_temp;
    logic        is_cal;
    logic        is_user;
    logic        status_ok;
    logic        temp_ok;
    logic        mem_rd;
    logic        mem_user_reg;
    logic [MEM_AW-1:0] mem_addr;
    logic [MEM_DW-1:0] cal_rd_data;
    logic [MEM_DW-1:0] user_rd_data;

    assign req_ready_o = (state_reg == QRR_IDLE);
    assign req_take    = req_valid_i && req_ready_o;
    assign is_status   = (req_cmd_i == STATUS_REQUEST_OFS);
    assign is_temp     = (req_cmd_i == TEMPERATURE_REQUEST_OFS);
    assign is_cal      = (req_cmd_i == CAL_MEM_READ_OFS);
    assign is_user     = (req_cmd_i == USER_MEM_READ_OFS);
    assign status_ok   = is_status && (instruction_value_i == STATUS_INSTR);
    assign temp_ok     = is_temp && (instruction_value_i == TEMPERATURE_INSTR);
    assign mem_rd      = req_take && (is_cal || is_user);
    assign mem_addr    = instruction_value_i[MEM_AW-1:0];

    // ------------------------------------------------------------
    // Memories
    // ------------------------------------------------------------
    qrr_byte_mem u_cal_mem (
        .clk_i     (clk_i),
        .wr_en_i   (cal_load_en_i),
        .wr_addr_i (load_addr_i),
        .wr_data_i (load_data_i),
        .rd_en_i   (mem_rd && is_cal),
        .rd_addr_i (mem_addr),
        .rd_data_o (cal_rd_data)
    );

    qrr_byte_mem u_user_mem (
        .clk_i     (clk_i),
        .wr_en_i   (user_load_en_i),
        .wr_addr_i (load_addr_i),
        .wr_data_i (load_data_i),
        .rd_en_i   (mem_rd && is_user),
        .rd_addr_i (mem_addr),
        .rd_data_o (user_rd_data)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        case (state_reg)
            QRR_IDLE:
            begin
                if (req_take && temp_ok)
                    state_next = QRR_TEMP;
                else if (mem_rd)
                    state_next = QRR_MEM;
                else
                    state_next = QRR_IDLE;
            end
            QRR_TEMP: state_next = temp_done_i ? QRR_IDLE : QRR_TEMP;
            QRR_MEM:  state_next = QRR_IDLE;
            default:  state_next = QRR_IDLE;
        endcase
    end

    logic        resp_valid_reg;
    logic        resp_error_reg;
    logic [31:0] word_reg;
    logic        temp_start_reg;
    logic [7:0]  status_req_reg;
    logic [7:0]  temp_req_reg;
    logic [15:0] cal_req_reg;
    logic [15:0] user_req_reg;
    logic        answer_now;
    logic        bad_req;
    logic [31:0] word_next;

    assign bad_req    = req_take && !status_ok && !temp_ok && !is_cal && !is_user;
    assign answer_now = (req_take && status_ok) || bad_req
                        || (state_reg == QRR_TEMP && temp_done_i) || (state_reg == QRR_MEM);
    assign word_next  = (state_reg == QRR_TEMP) ? {18'h00000, temp_code_i}
                      : (state_reg == QRR_MEM)  ? {24'h000000,
                                                   mem_user_reg ? user_rd_data : cal_rd_data}
                      : status_ok               ? {16'h0000, status_word}
                      : WORD_RESET;

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state_reg      <= QRR_IDLE;
            resp_valid_reg <= 1'b0;
            resp_error_reg <= 1'b0;
            word_reg       <= WORD_RESET;
            temp_start_reg <= 1'b0;
            mem_user_reg   <= 1'b0;
        end
        else
        begin
            state_reg      <= state_next;
            resp_valid_reg <= answer_now;
            resp_error_reg <= bad_req;
            temp_start_reg <= req_take && temp_ok;
            if (answer_now)
            begin
                word_reg <= word_next;
            end
            if (mem_rd)
            begin
                mem_user_reg <= is_user;
            end
        end
    end

    // Request registers keep the last written value
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            status_req_reg <= REQ8_RESET;
            temp_req_reg   <= REQ8_RESET;
            cal_req_reg    <= REQ16_RESET;
            user_req_reg   <= REQ16_RESET;
        end
        else if (req_take)
        begin
            if (is_status)
                status_req_reg <= instruction_value_i[7:0];
            if (is_temp)
                temp_req_reg <= instruction_value_i[7:0];
            if (is_cal)
                cal_req_reg <= instruction_value_i[15:0];
            if (is_user)
                user_req_reg <= instruction_value_i[15:0];
        end
    end

    assign resp_valid_o                      = resp_valid_reg;
    assign resp_error_o                      = resp_error_reg;
    assign returned_word_o                   = word_reg;
    assign temp_start_o                      = temp_start_reg;
    assign status_request_o                  = status_req_reg;
    assign temperature_request_o             = temp_req_reg;
    assign calibration_memory_read_request_o = cal_req_reg;
    assign user_memory_read_request_o        = user_req_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    status_answer_a: assert property (req_take && status_ok |=> resp_valid_o
        && returned_word_o == {16'h0000, $past(status_word)})
        else $error("status answer wrong");
    reserved_zero_a: assert property ($rose(resp_valid_o) && $past(req_take && status_ok)
        |-> (returned_word_o[15:0] & ST_RESERVED_MASK) == 16'h0000)
        else $error("reserved status bit set");
    lock_bits_a: assert property (req_take && status_ok |=>
        returned_word_o[ST_TEMP_COMPENSATED_CRYSTAL_OSC_LOCK_BIT] == $past(pin_reg[7]))
        else $error("crystal lock bit wrong");
    temp_start_a: assert property (req_take && temp_ok |=> temp_start_o ##1 !temp_start_o)
        else $error("sensor start missing");
    temp_word_a: assert property (state_reg == QRR_TEMP && temp_done_i |=> resp_valid_o
        && returned_word_o == {18'h00000, $past(temp_code_i)})
        else $error("temperature word wrong");
    mem_answer_a: assert property (mem_rd |=> ##1 resp_valid_o
        && returned_word_o[31:8] == 24'h000000)
        else $error("memory answer late or wide");
    mem_wrap_a: assert property (mem_rd |-> mem_addr == instruction_value_i[13:0])
        else $error("address not wrapped");
    bad_req_a: assert property (bad_req |=> resp_valid_o && resp_error_o
        && returned_word_o == WORD_RESET)
        else $error("bad request not flagged");
    busy_block_a: assert property (mem_rd |=> !req_ready_o ##1 (req_ready_o && resp_valid_o))
        else $error("ready while busy");

    status_cov_c: cover property (req_take && status_ok ##1 resp_valid_o);
    temp_cov_c:   cover property (req_take && temp_ok ##[1:20] resp_valid_o);
    user_cov_c:   cover property (mem_rd && is_user && instruction_value_i[14] ##2 resp_valid_o);

endmodule : qrr_responder

`default_nettype wire

// File: shared/qrr_pkg.sv
/*
 Package of the query request responder: request register offsets,
 instruction values, status word bit positions, reset values.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package qrr_pkg;

    // ------------------------------------------------------------
    // Request register offsets (command byte)
    // ------------------------------------------------------------
    localparam logic [7:0]  STATUS_REQUEST_OFS      = 8'h18;
    localparam logic [7:0]  TEMPERATURE_REQUEST_OFS = 8'h19;
    localparam logic [7:0]  CAL_MEM_READ_OFS        = 8'h20;
    localparam logic [7:0]  USER_MEM_READ_OFS       = 8'h22;

    // ------------------------------------------------------------
    // Instruction values and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] STATUS_INSTR            = 32'h0000_0001;
    localparam logic [31:0] TEMPERATURE_INSTR       = 32'h0000_0000;
    localparam logic [7:0]  REQ8_RESET              = 8'h00;
    localparam logic [15:0] REQ16_RESET             = 16'h0000;
    localparam logic [31:0] WORD_RESET              = 32'h0000_0000;

    // ------------------------------------------------------------
    // Status word bit positions
    // ------------------------------------------------------------
    localparam int          ST_TEMP_COMPENSATED_CRYSTAL_OSC_LOCK_BIT        = 15;
    localparam int          ST_VOLTAGE_TUNED_CRYSTAL_OSC_LOCK_BIT        = 14;
    localparam int          ST_LO1_MAIN_BIT         = 13;
    localparam int          ST_LO2_LOCK_BIT         = 12;
    localparam int          ST_LO3_LOCK_BIT         = 11;
    localparam int          ST_LO1_AUX1_BIT         = 10;
    localparam int          ST_LO1_AUX2_BIT         = 9;
    localparam int          ST_EXT_REF_BIT          = 7;
    localparam int          ST_REF_OUT_BIT          = 6;
    localparam int          ST_REF_LOCK_BIT         = 5;
    localparam int          ST_IF_PATH_BIT          = 4;
    localparam int          ST_STANDBY_BIT          = 2;
    localparam int          ST_BACKPLANE_BIT        = 1;
    localparam logic [15:0] ST_RESERVED_MASK        = 16'h0109;

    // ------------------------------------------------------------
    // Temperature and memory fields
    // ------------------------------------------------------------
    localparam int          TEMP_W                  = 14;
    localparam logic [31:0] TEMP_SIGN_MASK          = 32'h0000_2000;
    localparam int          MEM_AW                  = 14;
    localparam int          MEM_DW                  = 8;
    localparam int          PIN_COUNT               = 8;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        QRR_IDLE = 3'b001,
        QRR_TEMP = 3'b010,
        QRR_MEM  = 3'b100
    } qrr_state_t;

endpackage : qrr_pkg
